// ==== pkg/blank_filter_pkg.sv ====
/*
  Constants, states and carrier types for the compare-event blanking
  filter. Assumes one module clock shared by the filter, the period
  counter that produces the period-start pulse and the trip logic.
*/
package blank_filter_pkg;

  // Unblanked cycles at the start of every window
  localparam logic [1:0] OPEN_DELAY = 2'h3;
  // Hazard zone around the window's closing edge, in module clocks
  localparam logic [2:0] HAZARD_BEFORE = 3'h1;
  localparam logic [2:0] HAZARD_AFTER = 3'h3;
  // Counter widths and reset values
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  localparam logic [2:0] AGE_RESET = 3'h0;
  localparam logic [2:0] AGE_IDLE = 3'h7;

  // Window sequencer, one-hot
  typedef enum logic [2:0] {
    WIN_IDLE = 3'b001,
    WIN_OPENING = 3'b010,
    WIN_BLANKING = 3'b100
  } win_state_e;

  // Static configuration from the owning module
  typedef struct packed {
    logic filterEnable;
    logic blankEnable;
    logic [CNT_W-1:0] windowOffset;
    logic [CNT_W-1:0] windowWidth;
  } blank_cfg_s;

  // Observable filter state
  typedef struct packed {
    logic windowOpen;
    logic blanking;
    logic closeHazard;
  } blank_status_s;

endpackage

// ==== rtl/pwm_trip_blanking_window.sv ====
/*
  Blanking-window filter between the compare-event sources and the
  trip-zone unit of the pwm module. A window opens a programmed number
  of cycles after each period start, unless the previous window still runs at the offset match, and lasts a programmed width; it
  masks the filtered event only from its fourth cycle on, and it runs
  on across period boundaries. A trip that falls near the window's
  close is flagged on a one-cycle hazard status pulse, since its short
  tail reaches the trip-zone unit unmasked.
  Assumes the raw compare event, the period-start pulse and the
  configuration come from logic on sys_clk, so none of them is
  synchronised here, and that the configuration only changes while the
  filter is idle or in reset.
*/
// Function
// - Suppress compare trip events while the blanking window blanks.
// - A trip ending under three clocks after close may glitch output.
// - Trip ending 1 before to 3 after close: trip or no trip.
// - No blanking in the window's first 3 cycles; from the fourth on.
// - In the unblanked opening cycles the filtered event follows raw.
// - An open window carries on across a period boundary.
`timescale 1ns/100ps
`default_nettype none

module pwm_trip_blanking_window
  import blank_filter_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Configuration and period timing
  input wire blank_cfg_s cfg,
  input wire logic periodStart,
  // Compare event in, filtered event out to the trip-zone unit
  input wire logic rawCompareEvent,
  output logic filteredCompareEvent,
  // Filter state
  output blank_status_s status
);

  // Window sequencer state
  win_state_e state_ff, nxt_state;
  logic [CNT_W-1:0] offsetCnt_ff, nxt_offsetCnt;
  logic [CNT_W-1:0] widthCnt_ff, nxt_widthCnt;
  logic [1:0] openCnt_ff, nxt_openCnt;
  logic offsetArmed_ff, nxt_offsetArmed;

  // Output and hazard state
  logic filtered_ff, nxt_filtered;
  logic rawPrev_ff, nxt_rawPrev;
  logic [2:0] sinceClose_ff, nxt_sinceClose;
  logic hazard_ff, nxt_hazard;
  logic windowOpen_ff, nxt_windowOpen;
  logic blanking_ff, nxt_blanking;

  // Combinational helpers
  logic openNow;
  logic lastCycle;
  logic rawFall;
  logic blankNow;
  logic windowBusy;

  // Saturating step of the close-age counter
  function automatic logic [2:0] satInc3(input logic [2:0] v);
    satInc3 = (v == AGE_IDLE) ? v : 3'(v + 3'h1);
  endfunction

  // Count-down step shared by the width counter paths
  function automatic logic [CNT_W-1:0] decCnt(input logic [CNT_W-1:0] v);
    decCnt = CNT_W'(v - 1'b1);
  endfunction

  // Any window state but idle
  assign windowBusy = (state_ff != WIN_IDLE);
  // Window opens when the offset count meets the programmed offset.
  // A match while a window still runs is lost; one window at a time,
  // so a long window simply swallows the next period's opening.
  assign openNow = cfg.blankEnable && offsetArmed_ff &&
                   (offsetCnt_ff == cfg.windowOffset);
  assign lastCycle = windowBusy &&
                     (widthCnt_ff == CNT_RESET);
  assign rawFall = rawPrev_ff && !rawCompareEvent;
  // Mask only in the blanking state, never in the opening cycles
  assign blankNow = (state_ff == WIN_BLANKING);

  // Sequencer next state
  always_comb begin
    nxt_state = state_ff;
    nxt_offsetCnt = offsetCnt_ff;
    nxt_widthCnt = widthCnt_ff;
    nxt_openCnt = openCnt_ff;
    nxt_offsetArmed = offsetArmed_ff;
    // Offset timing restarts each period; the window itself does not
    if (periodStart) begin
      nxt_offsetCnt = CNT_RESET;
      nxt_offsetArmed = 1'b1;
    end else if (offsetArmed_ff) begin
      if (openNow) begin
        nxt_offsetArmed = 1'b0;
      end else begin
        nxt_offsetCnt = CNT_W'(offsetCnt_ff + 1'b1);
      end
    end
    // Window: idle, three unmasked cycles, then masking to the end
    unique case (state_ff)
      WIN_IDLE: begin
        if (openNow && (cfg.windowWidth != CNT_RESET)) begin
          nxt_state = WIN_OPENING;
          nxt_widthCnt = decCnt(cfg.windowWidth);
          nxt_openCnt = 2'h1;
        end
      end
      WIN_OPENING: begin
        // First cycles of the window pass events unmasked
        if (lastCycle) begin
          nxt_state = WIN_IDLE;
        end else begin
          nxt_widthCnt = decCnt(widthCnt_ff);
          if (openCnt_ff == OPEN_DELAY) begin
            nxt_state = WIN_BLANKING;
          end else begin
            nxt_openCnt = 2'(openCnt_ff + 2'h1);
          end
        end
      end
      WIN_BLANKING: begin
        // periodStart is ignored here, the window keeps running
        if (lastCycle) begin
          nxt_state = WIN_IDLE;
        end else begin
          nxt_widthCnt = decCnt(widthCnt_ff);
        end
      end
      default: begin
        nxt_state = WIN_IDLE;
      end
    endcase
    // Disabling blanking drops any window in progress
    if (!cfg.blankEnable) begin
      nxt_state = WIN_IDLE;
    end
  end

  // Sequencer registers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= WIN_IDLE;
      offsetCnt_ff <= CNT_RESET;
      widthCnt_ff <= CNT_RESET;
      openCnt_ff <= 2'h0;
      offsetArmed_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      offsetCnt_ff <= nxt_offsetCnt;
      widthCnt_ff <= nxt_widthCnt;
      openCnt_ff <= nxt_openCnt;
      offsetArmed_ff <= nxt_offsetArmed;
    end
  end

  // Filtered event, close-edge tracking and status next values
  always_comb begin
    // Status copies lag the state by one cycle
    nxt_rawPrev = rawCompareEvent;
    nxt_windowOpen = windowBusy;
    nxt_blanking = blankNow;
    // Filter path: bypass, mask, or follow the raw event
    if (!cfg.filterEnable) begin
      nxt_filtered = rawCompareEvent;
    end else if (blankNow) begin
      nxt_filtered = 1'b0;
    end else begin
      nxt_filtered = rawCompareEvent;
    end
    // Age since the window closed, saturating when far away
    if (lastCycle) begin
      nxt_sinceClose = AGE_RESET;
    end else begin
      nxt_sinceClose = satInc3(sinceClose_ff);
    end
    // Trip ending near close: the short tail reaches the trip unit.
    // Zone is the last window cycle and the three cycles after it; the
    // filtered path is left alone, only this pulse marks the risk.
    nxt_hazard = 1'b0;
    if (cfg.filterEnable && rawFall) begin
      if (windowBusy && (widthCnt_ff < CNT_W'(HAZARD_BEFORE))) begin
        nxt_hazard = 1'b1;
      end else if (sinceClose_ff < HAZARD_AFTER) begin
        nxt_hazard = 1'b1;
      end
    end
  end

  // Output registers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      filtered_ff <= 1'b0;
      rawPrev_ff <= 1'b0;
      sinceClose_ff <= AGE_IDLE;
      hazard_ff <= 1'b0;
      windowOpen_ff <= 1'b0;
      blanking_ff <= 1'b0;
    end else begin
      filtered_ff <= nxt_filtered;
      rawPrev_ff <= nxt_rawPrev;
      sinceClose_ff <= nxt_sinceClose;
      hazard_ff <= nxt_hazard;
      windowOpen_ff <= nxt_windowOpen;
      blanking_ff <= nxt_blanking;
    end
  end

  // Outputs straight from flip-flops
  assign filteredCompareEvent = filtered_ff;
  assign status.windowOpen = windowOpen_ff;
  assign status.blanking = blanking_ff;
  assign status.closeHazard = hazard_ff;

endmodule

`default_nettype wire

// ==== sim/blank_filter_sva.sv ====
/* Port checker for the compare-event blanking filter, bound to it.
   Assumes one clock sys_clk and nrst low while in reset. */
`timescale 1ns/100ps
`default_nettype none
module blank_filter_sva
  import blank_filter_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Watched ports
  input wire blank_cfg_s cfg,
  input wire logic periodStart,
  input wire logic rawCompareEvent,
  input wire logic filteredCompareEvent,
  input wire blank_status_s status
);
  logic [15:0] openCnt_ff, nxt_openCnt;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Cycles the window has been seen open
  always_comb nxt_openCnt = status.windowOpen ? openCnt_ff + 16'h1 : 16'h0;
  always_ff @(posedge sys_clk or negedge nrst)
    if (!nrst) openCnt_ff <= 16'h0;
    else openCnt_ff <= nxt_openCnt;
  // Opening cycles of a window, none masked
  sequence quietOpening;
    !status.blanking [*3];
  endsequence
  mask_event_a: assert property (
    cfg.filterEnable && status.blanking |-> !filteredCompareEvent)
    else $error("blanked event passed");
  blank_inside_a: assert property (
    status.blanking |-> status.windowOpen) else $error("blank outside");
  follow_raw_a: assert property (
    !(cfg.filterEnable && status.blanking)
    |-> filteredCompareEvent == $past(rawCompareEvent))
    else $error("filtered not following raw");
  open_delay_a: assert property (
    $rose(status.windowOpen) |-> quietOpening
    ##1 (status.blanking == (cfg.windowWidth > 16'h3)))
    else $error("blanking start wrong");
  window_length_a: assert property (
    $fell(status.windowOpen) |-> openCnt_ff == cfg.windowWidth)
    else $error("window length wrong");
  hazard_cause_a: assert property (
    status.closeHazard |-> cfg.filterEnable
    && $past(rawCompareEvent, 2) && !$past(rawCompareEvent))
    else $error("hazard without falling trip");
  hazard_pulse_a: assert property (
    status.closeHazard |=> !status.closeHazard)
    else $error("hazard longer than one cycle");
endmodule
bind pwm_trip_blanking_window blank_filter_sva u_blank_filter_sva (
  .sys_clk, .nrst, .cfg, .periodStart, .rawCompareEvent,
  .filteredCompareEvent, .status);
`default_nettype wire

// ==== sim/tb.sv ====
/* Self-checking bench: a cycle model notes the filtered value due.
   Assumes the trip source model and the bound checker. */
`timescale 1ns/100ps
`default_nettype none
module tb;
  import blank_filter_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  blank_cfg_s cfg = '0;
  logic [7:0] period = 8'h10, tripDelay = 8'h0, tripLen = 8'h0;
  logic periodStart, rawCompareEvent, filteredCompareEvent;
  blank_status_s status;
  logic [15:0] off, wc;
  logic arm, prevRaw, lastWin;
  logic quiet = 1'b0;
  logic [2:0] age;
  // Notes: filtered value and hazard pulse due after each edge
  logic q[$], qh[$];
  int fail_count = 0, n_checks = 0;
  always #2 sys_clk = ~sys_clk;
  trip_source_model u_trip_source_model (.sys_clk, .nrst, .period,
    .tripDelay, .tripLen, .periodStart, .rawCompareEvent);
  pwm_trip_blanking_window u_pwm_trip_blanking_window (.sys_clk, .nrst,
    .cfg, .periodStart, .rawCompareEvent, .filteredCompareEvent, .status);
  // Window model; wc is the window cycle, 0 when idle
  always @(posedge sys_clk) begin
    if (!nrst) begin
      arm = 1'b0; off = 16'h0; wc = 16'h0; q.delete();
      qh.delete();
      prevRaw = 1'b0;
      age = AGE_IDLE;
    end else begin
      q.push_back(rawCompareEvent && !(cfg.filterEnable && wc > 16'h3));
      // Hazard zone: last window cycle and the three cycles after close
      lastWin = wc != 16'h0 && wc == cfg.windowWidth;
      qh.push_back(cfg.filterEnable && prevRaw && !rawCompareEvent &&
        (lastWin || age < HAZARD_AFTER));
      age = lastWin ? 3'h0 : (age == AGE_IDLE) ? age : 3'(age + 3'h1);
      prevRaw = rawCompareEvent;
      if (!cfg.blankEnable) wc = 16'h0;
      else if (wc != 16'h0) wc = (wc == cfg.windowWidth) ? 16'h0 : wc + 16'h1;
      else if (arm && off == cfg.windowOffset && cfg.windowWidth != 16'h0)
        wc = 16'h1;
      arm = periodStart || (arm && off != cfg.windowOffset);
      off = periodStart ? 16'h0 : off + 16'h1;
    end
  end
  // Oldest note against the settled output
  always @(negedge sys_clk)
    if (nrst && q.size() != 0) begin
      n_checks++;
      if (filteredCompareEvent !== q[0]) begin
        fail_count++;
        $display("[FAIL] filtered expected %b seen %b", q[0],
          filteredCompareEvent);
      end
      n_checks++;
      if (status.closeHazard !== qh[0]) begin
        fail_count++;
        $display("[FAIL] closeHazard expected %b seen %b", qh[0],
          status.closeHazard);
      end
      // Compliant software: no trip may get through at all
      if (quiet) begin
        n_checks++;
        if (filteredCompareEvent !== 1'b0) begin
          fail_count++;
          $display("[FAIL] passed trip expected 0 seen %b",
            filteredCompareEvent);
        end
      end
      void'(q.pop_front());
      void'(qh.pop_front());
    end
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Short widths first, then random widths, some longer than a period
  initial begin
    void'($urandom(81));
    for (int i = 0; i < 40; i++) begin
      nrst = 1'b0;
      cfg.filterEnable = (i % 4) != 3;
      cfg.blankEnable = (i % 8) != 1;
      quiet = (i % 2 == 0) && (i >= 8);
      if (quiet) begin
        // Trip kept inside the masked part, clear of the close
        period = 8'($urandom_range(30, 40));
        cfg.windowOffset = 16'($urandom_range(0, 8));
        cfg.windowWidth = 16'($urandom_range(8, 16));
        tripDelay = 8'(cfg.windowOffset + 16'h5);
        tripLen = 8'($urandom_range(1, cfg.windowWidth - 6));
      end else begin
        cfg.windowWidth = i < 8 ? 16'(i) : 16'($urandom_range(4, 40));
        period = 8'($urandom_range(8, 30));
        cfg.windowOffset = 16'($urandom_range(0, period - 2));
        tripDelay = 8'($urandom_range(0, 40));
        tripLen = 8'($urandom_range(1, 12));
      end
      repeat (8) @(posedge sys_clk);
      #1 nrst = 1'b1;
      repeat (300) @(posedge sys_clk);
      #1;
    end
    complete_run();
  end
  // Watchdog
  initial begin
    #100000;
    fail_count++;
    complete_run();
  end
endmodule
`default_nettype wire

// ==== sim/trip_source_model.sv ====
/* Period counter and compare-trip source feeding the filter.
   Assumes the bench changes its inputs only while nrst is low. */
`timescale 1ns/100ps
`default_nettype none
module trip_source_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Period, trip delay and trip length
  input wire logic [7:0] period,
  input wire logic [7:0] tripDelay,
  input wire logic [7:0] tripLen,
  // To the filter
  output logic periodStart,
  output logic rawCompareEvent
);
  logic [7:0] cnt = 8'h0;
  logic live = 1'b0;
  initial periodStart = 1'b0;
  initial rawCompareEvent = 1'b0;
  // Trip ends fall anywhere, close edge included; quiet in reset.
  // Reset is taken at the edge, so its release is seen one edge late,
  // and a period starts on the first cycle after that.
  always @(posedge sys_clk) begin
    live = nrst;
    #1;
    if (!live) cnt = period - 8'h1;
    else cnt = (cnt == period - 8'h1) ? 8'h0 : cnt + 8'h1;
    periodStart = live && cnt == 8'h0;
    rawCompareEvent = live && cnt >= tripDelay && cnt < tripDelay + tripLen;
  end
endmodule
`default_nettype wire
